// >>> shared/ssl_consts.vh
// constants for the synthesizer serial load port
`ifndef SSL_CONSTS_VH
`define SSL_CONSTS_VH

// shift register and control field sizes
`define SSL_SHIFT_W      21
`define SSL_CTRL_W       2

// latch selector codes carried in the last two bits shifted in
`define SSL_CTRL_REF     2'h0
`define SSL_CTRL_RF      2'h1
`define SSL_CTRL_FUNC    2'h2

// field positions inside the stored function word (control bits removed)
`define SSL_PD_BIT       1
`define SSL_MUX_LSB      2
`define SSL_MUX_W        3

// multiplexed output selector codes
`define SSL_MUX_LOW      3'h0
`define SSL_MUX_LOCK     3'h1
`define SSL_MUX_RF       3'h2
`define SSL_MUX_REF      3'h3
`define SSL_MUX_HIGH     3'h4

// reset values
`define SSL_LATCH_RST    19'h00000
`define SSL_SHIFT_RST    21'h000000
`define SSL_SYNC_RST     1'h0

`endif

// >>> verilog/ssl_sync.v
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
`include "ssl_consts.vh"

module ssl_sync #(
   parameter WIDTH = 1
) (
   // clock and reset
   input  wire             clock,
   input  wire             reset,
   // asynchronous inputs
   input  wire [WIDTH-1:0] async_in,
   // synchronised outputs
   output reg  [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] stage_one;

   // first stage feeds only the second stage
   always @(posedge clock) begin
      if (reset) begin
         stage_one <= {WIDTH{`SSL_SYNC_RST}};
         sync_out  <= {WIDTH{`SSL_SYNC_RST}};
      end else begin
         stage_one <= async_in;
         sync_out  <= stage_one;
      end
   end

endmodule

// >>> verilog/ssl_port.v
// three-wire serial load port with latches, power control and output mux
`timescale 1ns/100ps
`include "ssl_consts.vh"

// Overview of operation
// - shift data in on serial clock rise
// - last two bits select target latch
// - load strobe rise copies into at most one latch (none for selector code 3)
// - enable low: power down, pump released
// - enable high: power follows power-down bit
// - mux output shows divider or lock detect
module ssl_port #(
   parameter SHIFT_W = `SSL_SHIFT_W
) (
   // clock and reset
   input  wire                 clock,
   input  wire                 reset,
   // serial pins from the host
   input  wire                 serial_clock,
   input  wire                 serial_data,
   input  wire                 load_strobe,
   // power pin
   input  wire                 chip_enable,
   // divider and lock detect sources
   input  wire                 rf_div_out,
   input  wire                 ref_div_out,
   input  wire                 lock_detect,
   // programmed latch contents
   output reg  [SHIFT_W-3:0]   ref_word,
   output reg  [SHIFT_W-3:0]   rf_word,
   output reg  [SHIFT_W-3:0]   func_word,
   // load events, one-hot ref, rf, function
   output reg  [2:0]           latch_loaded,
   // bits shifted since the last load, saturating
   output reg  [4:0]           bit_count,
   // power and analog control
   output reg                  powered_up,
   output reg                  pump_output_en,
   output reg                  divider_lock_mux_out
);

   localparam LATCH_W = SHIFT_W - `SSL_CTRL_W;
   localparam [4:0] COUNT_MAX = SHIFT_W[4:0];

   ////////////////////////////////////////////////////////////////////////////
   // input synchronisation

   wire [6:0] pins_async;
   wire [6:0] pins_sync;
   wire       sclk_s;
   wire       sdata_s;
   wire       strobe_s;
   wire       enable_s;
   wire       rf_div_s;
   wire       ref_div_s;
   wire       lock_s;

   // every pin crosses two flip-flops before use
   assign pins_async = {lock_detect, ref_div_out, rf_div_out, chip_enable,
                        load_strobe, serial_data, serial_clock};

   ssl_sync #(
      .WIDTH    (7)
   ) u_sync (
      .clock    (clock),
      .reset    (reset),
      .async_in (pins_async),
      .sync_out (pins_sync)
   );

   // name the synchronised pins
   assign sclk_s    = pins_sync[0];
   assign sdata_s   = pins_sync[1];
   assign strobe_s  = pins_sync[2];
   assign enable_s  = pins_sync[3];
   assign rf_div_s  = pins_sync[4];
   assign ref_div_s = pins_sync[5];
   assign lock_s    = pins_sync[6];

   ////////////////////////////////////////////////////////////////////////////
   // edge detection on the serial clock and load strobe

   reg  sclk_prev;
   reg  strobe_prev;
   wire sclk_rise;
   wire strobe_rise;

   // previous values of the synchronised levels
   always @(posedge clock) begin
      if (reset) begin
         sclk_prev   <= 1'h0;
         strobe_prev <= 1'h0;
      end else begin
         sclk_prev   <= sclk_s;
         strobe_prev <= strobe_s;
      end
   end

   // rising edges, one clock cycle wide
   assign sclk_rise   = sclk_s & ~sclk_prev;
   assign strobe_rise = strobe_s & ~strobe_prev;

   ////////////////////////////////////////////////////////////////////////////
   // shift register

   reg [SHIFT_W-1:0] shift_reg;

   // data and clock share the same delay, so data is taken as it stood
   // when the serial clock rose; earlier bits move toward the top
   always @(posedge clock) begin
      if (reset) begin
         shift_reg <= `SSL_SHIFT_RST;
      end else if (sclk_rise) begin
         shift_reg <= {shift_reg[SHIFT_W-2:0], sdata_s};
      end
   end

   // count bits since the last load, held at the word length
   always @(posedge clock) begin
      if (reset) begin
         bit_count <= 5'h00;
      end else if (strobe_rise) begin
         bit_count <= 5'h00;
      end else if (sclk_rise && bit_count != COUNT_MAX) begin
         bit_count <= bit_count + 5'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // latch transfer

   wire [`SSL_CTRL_W-1:0] ctrl_bits;
   wire [LATCH_W-1:0]     data_bits;

   // the two bits shifted in last choose the latch
   assign ctrl_bits = shift_reg[`SSL_CTRL_W-1:0];
   assign data_bits = shift_reg[SHIFT_W-1:`SSL_CTRL_W];

   // load at most one latch on a strobe rise (none for selector code 3); otherwise all hold
   always @(posedge clock) begin
      if (reset) begin
         ref_word     <= `SSL_LATCH_RST;
         rf_word      <= `SSL_LATCH_RST;
         func_word    <= `SSL_LATCH_RST;
         latch_loaded <= 3'h0;
      end else begin
         latch_loaded <= 3'h0;
         if (strobe_rise) begin
            case (ctrl_bits)
               `SSL_CTRL_REF: begin
                  ref_word        <= data_bits;
                  latch_loaded[0] <= 1'h1;
               end
               `SSL_CTRL_RF: begin
                  rf_word         <= data_bits;
                  latch_loaded[1] <= 1'h1;
               end
               `SSL_CTRL_FUNC: begin
                  func_word       <= data_bits;
                  latch_loaded[2] <= 1'h1;
               end
               default: begin
                  // unused selector code: no latch changes
                  latch_loaded <= 3'h0;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // power control

   wire next_powered_up;

   // enable low forces power-down; high defers to the programmed bit
   assign next_powered_up = enable_s & ~func_word[`SSL_PD_BIT];

   // pump output is driven only while powered up
   always @(posedge clock) begin
      if (reset) begin
         powered_up     <= 1'h0;
         pump_output_en <= 1'h0;
      end else begin
         powered_up     <= next_powered_up;
         pump_output_en <= next_powered_up;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // multiplexed output

   wire [`SSL_MUX_W-1:0] mux_sel;
   reg                   next_mux_out;

   // selector field of the function word
   assign mux_sel = func_word[`SSL_MUX_LSB+`SSL_MUX_W-1:`SSL_MUX_LSB];

   // choose the source for the shared output pin
   always @* begin
      next_mux_out = 1'h0;
      case (mux_sel)
         `SSL_MUX_LOW:  next_mux_out = 1'h0;
         `SSL_MUX_LOCK: next_mux_out = lock_s;
         `SSL_MUX_RF:   next_mux_out = rf_div_s;
         `SSL_MUX_REF:  next_mux_out = ref_div_s;
         `SSL_MUX_HIGH: next_mux_out = 1'h1;
         default:       next_mux_out = 1'h0;
      endcase
   end

   // registered pin driver
   always @(posedge clock) begin
      if (reset) begin
         divider_lock_mux_out <= 1'h0;
      end else begin
         divider_lock_mux_out <= next_mux_out;
      end
   end

endmodule

// >>> dv/ssl_host.sv
// host model driving the three-wire serial load pins
`timescale 1ns/100ps
module ssl_host (
   // serial pins toward the port
   output logic serial_clock,
   output logic serial_data,
   output logic load_strobe
);
   // idle pins, clock stands still between words
   initial begin
      serial_clock = 0;
      serial_data = 0;
      load_strobe = 0;
   end
   // shift a word msb first, then raise the strobe
   task send_word(input logic [20:0] w);
      // step off the system clock edges so no pin moves on a sampling edge
      #2;
      for (int i = 20; i >= 0; i--) begin
         serial_data = w[i];
         #31 serial_clock = 1;
         #62.5 serial_clock = 0;
         #1 serial_data = ~serial_data; // hold over, line no longer shows the bit
         #30.5;
      end
      #40 load_strobe = 1;
      #200 load_strobe = 0;
   endtask
endmodule

// >>> dv/ssl_port_properties.sv
// concurrent checks on the serial load port outputs
`timescale 1ns/100ps
module ssl_port_properties #(
   parameter SHIFT_W = 21
) (
   // clock, reset and pins
   input wire logic clock, reset, serial_clock, serial_data, load_strobe, chip_enable,
   input wire logic rf_div_out, ref_div_out, lock_detect,
   // latches and status
   input wire logic [SHIFT_W-3:0] ref_word, rf_word, func_word,
   input wire logic [2:0] latch_loaded,
   input wire logic [4:0] bit_count,
   input wire logic powered_up, pump_output_en, divider_lock_mux_out
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (reset);
   // load events and latch holding
   property p_one_latch; $onehot0(latch_loaded); endproperty
   a_one_latch: assert property (p_one_latch) else $error("two latches loaded");
   property p_load_cause; |latch_loaded |-> $past(load_strobe, 2); endproperty
   a_load_cause: assert property (p_load_cause) else $error("load without strobe");
   property p_hold; $changed({ref_word, rf_word, func_word}) |-> |latch_loaded; endproperty
   a_hold: assert property (p_hold) else $error("latch changed without load");
   property p_step; $changed(bit_count) && bit_count != 0 |-> bit_count == $past(bit_count) + 5'h01; endproperty
   a_step: assert property (p_step) else $error("bit count jumped");
   // power control
   property p_pump; pump_output_en == powered_up; endproperty
   a_pump: assert property (p_pump) else $error("pump enable differs from power");
   property p_ce_low; !chip_enable [*3] |=> !powered_up; endproperty
   a_ce_low: assert property (p_ce_low) else $error("powered with enable low");
   property p_pd_bit; func_word[1] |=> !powered_up; endproperty
   a_pd_bit: assert property (p_pd_bit) else $error("powered with power-down bit");
   property p_power_up; (chip_enable && !func_word[1]) [*3] |=> powered_up; endproperty
   a_power_up: assert property (p_power_up) else $error("not powered up");
   // output mux follows lock detect three edges late
   property p_mux_lock; (func_word[4:2] == 3'h1) [*4] |-> divider_lock_mux_out == $past(lock_detect, 3); endproperty
   a_mux_lock: assert property (p_mux_lock) else $error("mux not showing lock");
   c_func: cover property (latch_loaded[2]);
   c_power: cover property ($rose(powered_up));
   c_full: cover property (bit_count == 5'd21);
endmodule

// >>> dv/tb_top.sv
// testbench for the serial load port
`timescale 1ns/100ps
module tb_top;
   logic clock = 0, reset = 1, chip_enable = 0, rf_div_out = 0, ref_div_out = 0, lock_detect = 0;
   wire serial_clock, serial_data, load_strobe, powered_up, pump_output_en, divider_lock_mux_out;
   wire [18:0] ref_word, rf_word, func_word;
   wire [2:0] latch_loaded;
   wire [4:0] bit_count;
   logic [18:0] exp_w [3] = '{0, 0, 0};
   // corner words: power-down, mux high, all-ones ref, then mux lock, rf and ref
   logic [20:0] hand [6] = '{21'h00000A, 21'h000042, 21'h1FFFFC, 21'h000012, 21'h000022, 21'h000032};
   logic [20:0] w;
   logic [4:0] peak_count = 0;
   int load_cnt [3] = '{0, 0, 0};
   int exp_cnt [3] = '{0, 0, 0};
   int fails = 0, num_checks = 0, cycles = 0;
   ssl_port #(
      .SHIFT_W              (21)
   ) uut (
      .clock                (clock),
      .reset                (reset),
      .serial_clock         (serial_clock),
      .serial_data          (serial_data),
      .load_strobe          (load_strobe),
      .chip_enable          (chip_enable),
      .rf_div_out           (rf_div_out),
      .ref_div_out          (ref_div_out),
      .lock_detect          (lock_detect),
      .ref_word             (ref_word),
      .rf_word              (rf_word),
      .func_word            (func_word),
      .latch_loaded         (latch_loaded),
      .bit_count            (bit_count),
      .powered_up           (powered_up),
      .pump_output_en       (pump_output_en),
      .divider_lock_mux_out (divider_lock_mux_out)
   );
   ssl_host host (.serial_clock(serial_clock), .serial_data(serial_data), .load_strobe(load_strobe));
   // count load pulses per latch; they stand for one cycle only
   always @(negedge clock) begin
      for (int k = 0; k < 3; k++) if (latch_loaded[k]) load_cnt[k]++;
   end
   // bits counted when the strobe pin rises, before the count clears
   always @(posedge load_strobe) peak_count = bit_count;
   // clock and hang limit
   initial forever #5 clock = ~clock;
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         give_verdict();
      end
   end
   // expected mux output for a select code
   function logic exp_mux(input logic [2:0] c);
      case (c)
         3'h1: return lock_detect;
         3'h2: return rf_div_out;
         3'h3: return ref_div_out;
         3'h4: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction
   task check(input string name, input logic [18:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task give_verdict;
      if (fails == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // corner words first, then random words over every selector
   initial begin
      w = 21'($urandom(32'h015B));
      repeat (20) @(negedge clock);
      reset = 0;
      repeat (3) @(negedge clock);
      check("func_word", func_word, 0);
      for (int i = 0; i < 16; i++) begin
         w = (i < 6) ? hand[i] : 21'($urandom);
         if (i >= 6) w[1:0] = 2'(i);
         chip_enable = (i < 2) | 1'($urandom);
         lock_detect = 1'($urandom);
         rf_div_out = 1'($urandom);
         ref_div_out = 1'($urandom);
         host.send_word(w);
         if (w[1:0] != 2'h3) begin
            exp_w[w[1:0]] = w[20:2];
            exp_cnt[w[1:0]]++;
         end
         repeat (8) @(negedge clock);
         check("ref_loads", 19'(load_cnt[0]), 19'(exp_cnt[0]));
         check("rf_loads", 19'(load_cnt[1]), 19'(exp_cnt[1]));
         check("func_loads", 19'(load_cnt[2]), 19'(exp_cnt[2]));
         check("bit_count_at_load", peak_count, 21);
         check("ref_word", ref_word, exp_w[0]);
         check("rf_word", rf_word, exp_w[1]);
         check("func_word", func_word, exp_w[2]);
         check("bit_count", bit_count, 0);
         check("powered_up", powered_up, chip_enable & ~exp_w[2][1]);
         check("pump_en", pump_output_en, chip_enable & ~exp_w[2][1]);
         check("mux_out", divider_lock_mux_out, exp_mux(exp_w[2][4:2]));
      end
      give_verdict();
   end
endmodule
bind ssl_port ssl_port_properties #(.SHIFT_W(SHIFT_W)) chk (
   .clock                (clock),
   .reset                (reset),
   .serial_clock         (serial_clock),
   .serial_data          (serial_data),
   .load_strobe          (load_strobe),
   .chip_enable          (chip_enable),
   .rf_div_out           (rf_div_out),
   .ref_div_out          (ref_div_out),
   .lock_detect          (lock_detect),
   .ref_word             (ref_word),
   .rf_word              (rf_word),
   .func_word            (func_word),
   .latch_loaded         (latch_loaded),
   .bit_count            (bit_count),
   .powered_up           (powered_up),
   .pump_output_en       (pump_output_en),
   .divider_lock_mux_out (divider_lock_mux_out)
);
